//--- src/spp_port.v
// Operation
// - master toggles the serial clock one full cycle per data bit
// - serial clock runs only during a transfer, word-length cycles
// - slave ignores serial clock while its select is high
// - data launched on one clock edge and captured on the other
// - polarity and phase bits from the control port fix the format
// - select input is active low, driven by an external master
// - select going low while master raises a multimaster error
// - master-out pin drives data as master, receives as slave
// - a flag output of the master drives the slave's select
// - master-in pin receives data as master, drives as slave
`include "spp_defines.vh"
`default_nettype none
module spp_port #(
  parameter WORD_BITS = `SPP_WORD_BITS,
  parameter FLAGS = `SPP_FLAG_COUNT
) (
  input wire clock,
  input wire reset,
  input wire ctl_enable,
  input wire ctl_master,
  input wire ctl_polarity,
  input wire ctl_phase,
  input wire [15:0] ctl_half_div,
  input wire [1:0] ctl_flag_sel,
  input wire ctl_error_clear,
  input wire tx_valid,
  input wire [WORD_BITS-1:0] tx_data,
  output reg tx_ready,
  output reg rx_valid,
  output reg [WORD_BITS-1:0] rx_data,
  output reg busy,
  output reg multimaster_error,
  input wire serial_port_clock_in,
  output reg serial_port_clock_out,
  output reg serial_port_clock_oe_n,
  input wire port_device_select_n,
  input wire mosi_in,
  output reg mosi_out,
  output reg mosi_oe_n,
  input wire miso_in,
  output reg miso_out,
  output reg miso_oe_n,
  output reg [FLAGS-1:0] slave_select_flag_output
);
  localparam CW = $clog2(WORD_BITS + 1);
  localparam [CW-1:0] LAST = WORD_BITS[CW-1:0];

  // every pin passes two flops before any logic reads it
  wire sck_s, sel_n_s, mosi_s, miso_s;
  spp_sync u_sck (.clock(clock), .reset(reset), .d(serial_port_clock_in), .q(sck_s));
  spp_sync u_sel (.clock(clock), .reset(reset), .d(port_device_select_n), .q(sel_n_s));
  spp_sync u_mosi (.clock(clock), .reset(reset), .d(mosi_in), .q(mosi_s));
  spp_sync u_miso (.clock(clock), .reset(reset), .d(miso_in), .q(miso_s));

  // sequencer state, divider, bit counter and shifter
  reg [1:0] st_q;
  reg [15:0] div_q;
  reg [CW-1:0] bit_q;
  reg half_q;
  reg sck_q;
  reg [WORD_BITS-1:0] sh_q;
  reg sck_prev_q;
  reg sel_prev_q;
  reg [FLAGS-1:0] flag_d;

  wire master_on = ctl_enable & ctl_master;
  wire slave_on = ctl_enable & ~ctl_master;
  // the half period must outlast the three-cycle pin round trip
  wire tick = (div_q == 16'h0000);
  // phase 0 samples on the leading edge, phase 1 launches on it
  wire sck_rise = sck_s & ~sck_prev_q;
  wire sck_fall = ~sck_s & sck_prev_q;
  wire lead = ctl_polarity ? sck_fall : sck_rise;
  wire trail = ctl_polarity ? sck_rise : sck_fall;
  wire slave_act = slave_on & ~sel_n_s;
  wire sel_fall = sel_prev_q & ~sel_n_s;
  // a master word starts from idle unless a clash is pending or arriving
  wire start = master_on & (st_q == `SPP_ST_IDLE) & tx_valid &
               ~multimaster_error & ~sel_fall;

  // decode flag select to one-hot low
  function [FLAGS-1:0] flag_hot;
    input [1:0] idx;
    integer i;
    begin
      flag_hot = {FLAGS{1'b1}};
      for (i = 0; i < FLAGS; i = i + 1) begin
        if (idx == i[1:0]) begin
          flag_hot[i] = 1'b0;
        end
      end
    end
  endfunction

  // select flag drops with the load and rises after the last half period
  always @* begin
    flag_d = {FLAGS{1'b1}};
    if (st_q != `SPP_ST_IDLE || start) begin
      flag_d = flag_hot(ctl_flag_sel);
    end
  end

  // master sequencer and slave shifter
  always @(posedge clock) begin
    if (reset) begin
      st_q <= `SPP_ST_IDLE;
      div_q <= 16'h0000;
      bit_q <= {CW{1'b0}};
      half_q <= 1'b0;
      sck_q <= 1'b0;
      sh_q <= {WORD_BITS{1'b0}};
      sck_prev_q <= 1'b1; // matches the synchroniser, no false edge
      sel_prev_q <= 1'b1;
      tx_ready <= 1'b0;
      rx_valid <= 1'b0;
      rx_data <= {WORD_BITS{1'b0}};
      busy <= 1'b0;
      multimaster_error <= 1'b0;
      serial_port_clock_out <= 1'b0;
      serial_port_clock_oe_n <= 1'b1;
      mosi_out <= 1'b1;
      mosi_oe_n <= 1'b1;
      miso_out <= 1'b1;
      miso_oe_n <= 1'b1;
      slave_select_flag_output <= {FLAGS{1'b1}};
    end else begin
      sck_prev_q <= sck_s;
      sel_prev_q <= sel_n_s;
      rx_valid <= 1'b0;
      slave_select_flag_output <= flag_d;
      // set wins over clear
      if (master_on & sel_fall) begin
        multimaster_error <= 1'b1;
      end else if (ctl_error_clear) begin
        multimaster_error <= 1'b0;
      end
      div_q <= tick ? ctl_half_div : div_q - 16'h0001;
      serial_port_clock_oe_n <= ~master_on;
      mosi_oe_n <= ~master_on;
      miso_oe_n <= ~slave_act;
      tx_ready <= master_on ? (st_q == `SPP_ST_IDLE) : ~slave_act & ~busy;
      serial_port_clock_out <= sck_q ^ ctl_polarity;
      if (master_on) begin
        case (st_q)
          `SPP_ST_IDLE: begin
            sck_q <= 1'b0;
            busy <= 1'b0;
            if (start) begin
              sh_q <= tx_data;
              mosi_out <= tx_data[WORD_BITS-1];
              bit_q <= {CW{1'b0}};
              half_q <= 1'b0;
              busy <= 1'b1;
              tx_ready <= 1'b0;
              st_q <= `SPP_ST_SEL;
            end
          end
          `SPP_ST_SEL: begin
            if (tick) begin
              st_q <= `SPP_ST_RUN;
            end
          end
          `SPP_ST_RUN: begin
            if (multimaster_error) begin
              sck_q <= 1'b0;
              st_q <= `SPP_ST_END;
            end else if (tick) begin
              sck_q <= ~sck_q;
              half_q <= ~half_q;
              if (half_q == ctl_phase) begin
                // sample edge
                sh_q <= {sh_q[WORD_BITS-2:0], miso_s};
              end else begin
                // launch edge, the first bit already stands from the load
                mosi_out <= sh_q[WORD_BITS-1];
              end
              if (half_q) begin
                bit_q <= bit_q + {{(CW-1){1'b0}}, 1'b1};
                if (bit_q + {{(CW-1){1'b0}}, 1'b1} == LAST) begin
                  st_q <= `SPP_ST_END;
                end
              end
            end
          end
          default: begin
            if (tick) begin
              rx_data <= sh_q;
              rx_valid <= ~multimaster_error;
              st_q <= `SPP_ST_IDLE;
            end
          end
        endcase
      end else begin
        st_q <= `SPP_ST_IDLE;
        sck_q <= 1'b0;
        if (~slave_act) begin
          bit_q <= {CW{1'b0}};
          busy <= 1'b0;
          if (tx_valid & ~busy) begin
            sh_q <= tx_data;
            miso_out <= tx_data[WORD_BITS-1];
          end
        end else begin
          busy <= 1'b1;
          if (ctl_phase ? trail : lead) begin
            sh_q <= {sh_q[WORD_BITS-2:0], mosi_s};
            bit_q <= bit_q + {{(CW-1){1'b0}}, 1'b1};
            if (bit_q + {{(CW-1){1'b0}}, 1'b1} == LAST) begin
              rx_data <= {sh_q[WORD_BITS-2:0], mosi_s};
              rx_valid <= 1'b1;
              bit_q <= {CW{1'b0}};
            end
          end else if (ctl_phase ? lead : trail) begin
            miso_out <= sh_q[WORD_BITS-1];
          end
        end
      end
    end
  end
endmodule // spp_port
`default_nettype wire

//--- src/spp_defines.vh
`ifndef SPP_DEFINES_VH
`define SPP_DEFINES_VH
// default word length in bits
`define SPP_WORD_BITS 8
// default divider: one less than the system cycles per half serial clock period
`define SPP_HALF_DIV 16'h0010
// slave-select flag outputs
`define SPP_FLAG_COUNT 4
// master state machine codes
`define SPP_ST_IDLE 2'h0
`define SPP_ST_SEL 2'h1
`define SPP_ST_RUN 2'h2
`define SPP_ST_END 2'h3
`endif

//--- src/spp_sync.v
`default_nettype none
// two-flop synchroniser for one pin
module spp_sync (
  input wire clock,
  input wire reset,
  input wire d,
  output reg q
);
  reg meta_q;
  // first flop feeds only the second
  always @(posedge clock) begin
    if (reset) begin
      meta_q <= 1'b1;
      q <= 1'b1;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule // spp_sync
`default_nettype wire

//--- sim/spp_assertions.sv
`default_nettype none
module spp_chk #(parameter WORD_BITS = 8, parameter FLAGS = 4) (
  input wire clock,
  input wire reset,
  input wire ctl_master,
  input wire busy,
  input wire rx_valid,
  input wire multimaster_error,
  input wire serial_port_clock_out,
  input wire port_device_select_n,
  input wire mosi_oe_n,
  input wire miso_oe_n,
  input wire [FLAGS-1:0] slave_select_flag_output
);
  logic [7:0] edge_q;
  logic prev_q;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // count serial clock toggles over one word
  always @(posedge clock) begin
    prev_q <= serial_port_clock_out;
    if (reset || (!busy && !rx_valid)) edge_q <= 8'h00;
    else if (prev_q != serial_port_clock_out) edge_q <= edge_q + 8'h01;
  end
  a_bit_clocks: assert property (rx_valid && ctl_master |-> edge_q == 2 * WORD_BITS)
    else $error("clock toggles per word");
  a_mosi_drive: assert property (ctl_master && busy |-> !mosi_oe_n)
    else $error("mosi not driven");
  a_mosi_free: assert property (!ctl_master && !$past(ctl_master) |-> mosi_oe_n)
    else $error("mosi driven as slave");
  a_miso_free: assert property (ctl_master && $past(ctl_master) |-> miso_oe_n)
    else $error("miso driven as master");
  a_flag_word: assert property (ctl_master && busy |-> $onehot(~slave_select_flag_output))
    else $error("select flag in word");
  a_flag_idle: assert property (!busy && !rx_valid |-> &slave_select_flag_output)
    else $error("select flag when idle");
  a_clash_seen: assert property (ctl_master && $fell(port_device_select_n)
    |-> ##[1:6] multimaster_error) else $error("clash missed");
  a_start_refused: assert property (ctl_master && multimaster_error && !busy |=> !busy)
    else $error("start during clash");
  a_slave_quiet: assert property (!ctl_master && !$past(ctl_master)
    && $past(port_device_select_n, 3) |-> !rx_valid) else $error("deselected slave received");
endmodule // spp_chk
bind spp_port spp_chk #(.WORD_BITS(WORD_BITS), .FLAGS(FLAGS)) spp_chk_inst (.clock, .reset,
  .ctl_master, .busy, .rx_valid, .multimaster_error, .serial_port_clock_out,
  .port_device_select_n, .mosi_oe_n, .miso_oe_n, .slave_select_flag_output);
`default_nettype wire

//--- sim/spp_slv.sv
`default_nettype none
module spp_slv (
  input wire logic sck,
  input wire logic ss_n,
  input wire logic mosi,
  input wire logic [1:0] mode,
  input wire logic [7:0] word,
  output var logic [7:0] rx,
  output wire logic miso
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] tx;
  // reply loads as select falls, phase 1 waits for its first leading edge
  always @(negedge ss_n) tx = mode[0] ? {1'b1, word} : {word, 1'b0};
  // capture on one edge and shift on the other, only while selected
  always @(sck) if (!ss_n) begin
    if ((sck != mode[1]) ^ mode[0]) rx = {rx[6:0], mosi};
    else tx = {tx[7:0], 1'b0};
  end
  assign miso = ss_n | tx[8]; // pulled up when released
endmodule // spp_slv
`default_nettype wire

//--- sim/spp_port_bench.sv
`default_nettype none
module spp_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 0, reset = 1, ctl_master = 1, ctl_polarity = 0, ctl_phase = 0, tx_valid = 0;
  logic ctl_enable = 1, ctl_error_clear = 0, tx_ready, ext_sck = 1, ext_mosi = 1;
  logic port_device_select_n = 1, busy, rx_valid, multimaster_error;
  logic serial_port_clock_out, serial_port_clock_oe_n, mosi_out, mosi_oe_n, miso_out, miso_oe_n;
  logic [15:0] ctl_half_div = 16'h000f; // 160 ns serial clock period
  logic [1:0] ctl_flag_sel = 2'h0;
  logic [3:0] slave_select_flag_output;
  logic [7:0] tx_data = 8'h00, sw = 8'h00, m_rx, rx_data, got = 8'h00, m_word = 8'h00;
  logic [31:0] seed = 32'h24d0_f580;
  int num_errors = 0, check_count = 0, cyc = 0;
  // released clock and mosi pins show the external master, which idles at the pull-up level; released miso shows the slave model
  wire logic m_miso, sck_l = serial_port_clock_oe_n ? ext_sck : serial_port_clock_out;
  wire logic mosi_l = mosi_oe_n ? ext_mosi : mosi_out, miso_l = miso_oe_n ? m_miso : miso_out;
  // port under test, slave model on the selected flag line
  spp_port spp_port_inst (.clock, .reset, .ctl_enable, .ctl_master, .ctl_polarity,
    .ctl_phase, .ctl_half_div, .ctl_flag_sel, .ctl_error_clear, .tx_valid, .tx_data,
    .tx_ready, .rx_valid, .rx_data, .busy, .multimaster_error, .serial_port_clock_in(sck_l),
    .serial_port_clock_out, .serial_port_clock_oe_n, .port_device_select_n, .mosi_in(mosi_l),
    .mosi_out, .mosi_oe_n, .miso_in(miso_l), .miso_out, .miso_oe_n, .slave_select_flag_output);
  spp_slv spp_slv_inst (.sck(sck_l), .ss_n(slave_select_flag_output[ctl_flag_sel]),
    .mosi(mosi_l), .mode({ctl_polarity, ctl_phase}), .word(sw), .rx(m_rx), .miso(m_miso));
  initial forever #2.5 clock = ~clock;
  // cut a hung run short
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) num_errors++;
    if (cyc == 20000) complete_run();
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) num_errors++;
    if (got !== exp) $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
  endtask
  // wait a bounded time for a received word, a missing one is a mismatch
  task automatic wait_rx();
    for (int n = 0; n < 3000 && rx_valid !== 1'b1; n++) @(negedge clock);
    chk({7'h00, rx_valid}, 8'h01);
  endtask
  task automatic complete_run();
    $display("%0d checks, %0d mismatches", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // master words in all four formats, then a select clash and a slave switch
  initial begin
    repeat (20) @(negedge clock);
    reset = 0;
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      {ctl_polarity, ctl_phase, ctl_flag_sel, tx_data, sw} = {i[1:0], seed[17:0]};
      repeat (3) @(negedge clock);
      chk({7'h00, tx_ready}, 8'h01);
      tx_valid = 1;
      @(negedge clock);
      tx_valid = 0;
      wait_rx();
      chk(rx_data, sw);
      chk(m_rx, tx_data);
    end
    $display("master words done");
    port_device_select_n = 0; // held high until now
    repeat (8) @(negedge clock);
    tx_valid = 1;
    repeat (8) @(negedge clock);
    chk({6'h00, multimaster_error, busy}, 8'h02);
    tx_valid = 0;
    ctl_master = 0;
    repeat (4) @(negedge clock);
    chk({7'h00, mosi_oe_n}, 8'h01);
    $display("clash and slave switch done");
    // external master: clear the error, preload while deselected, one mode 0 word
    port_device_select_n = 1;
    ctl_error_clear = 1;
    {ctl_polarity, ctl_phase} = 2'b00;
    seed = xs(seed);
    {tx_data, m_word} = seed[15:0];
    @(negedge clock);
    ctl_error_clear = 0;
    repeat (4) @(negedge clock);
    ext_sck = 0;
    tx_valid = 1;
    @(negedge clock);
    tx_valid = 0;
    repeat (4) @(negedge clock);
    chk({6'h00, multimaster_error, tx_ready}, 8'h01);
    port_device_select_n = 0;
    repeat (16) @(negedge clock);
    chk({7'h00, miso_oe_n}, 8'h00);
    for (int b = 7; b >= 0; b--) begin
      ext_mosi = m_word[b];
      repeat (16) @(negedge clock);
      got = {got[6:0], miso_l};
      ext_sck = 1;
      if (b == 0) wait_rx();
      else repeat (16) @(negedge clock);
      ext_sck = 0;
    end
    chk(rx_data, m_word);
    chk(got, tx_data);
    port_device_select_n = 1;
    repeat (4) @(negedge clock);
    chk({7'h00, busy}, 8'h00);
    ctl_enable = 0;
    repeat (4) @(negedge clock);
    chk({5'h00, serial_port_clock_oe_n, mosi_oe_n, miso_oe_n}, 8'h07);
    $display("slave word done");
    complete_run();
  end
endmodule // spp_port_bench
`default_nettype wire
